/* File: rtl/ueim_defs.vh */
`ifndef UEIM_DEFS_VH
`define UEIM_DEFS_VH

// register byte offsets
`define UEIM_OFF_IRQ_STATUS     4'h0
`define UEIM_OFF_IRQ_ENABLE     4'h4
`define UEIM_OFF_ERR_STATUS     4'h8
`define UEIM_OFF_ERR_ENABLE     4'hc

// error register field positions
`define UEIM_BIT_PID            0
`define UEIM_BIT_TOKEN_CRC      1
`define UEIM_BIT_DATA_CRC       2
`define UEIM_BIT_FIELD_SIZE     3
`define UEIM_BIT_TURNAROUND     4
`define UEIM_BIT_BITSTUFF       7

// implemented bits of the error registers, bits 6:5 are absent
`define UEIM_ERR_IMPL_MASK      8'h9f
// implemented bits of the interrupt enable register
`define UEIM_IRQ_EN_IMPL_MASK   8'h7f
// summary flag position in the status and enable registers
`define UEIM_BIT_SUMMARY        1

// reset values
`define UEIM_RST_ERR_ENABLE     8'h00
`define UEIM_RST_ERR_STATUS     8'h00
`define UEIM_RST_IRQ_ENABLE     8'h00

// bus turnaround limit in bit times of idle after end of packet
`define UEIM_TURN_LIMIT         5'd16

// bus responses
`define UEIM_RESP_OKAY          2'b00
`define UEIM_RESP_SLVERR        2'b10

`endif

/* File: rtl/ueim_top.v */
// How it works
// [RL1] set enable bit lets its flag through
// [RL2] flags set regardless of enable bits
// [RL3] bit 7 gates bit stuff error
// [RL4] bit 4 gates turnaround time-out
// [RL5] bit 3 gates data field size error
// [RL6] bit 2 gates data crc failure
// [RL7] bit 1 gates token crc error
// [RL8] bit 0 gates pid check failure
// [RL9] enable bits 6:5 read zero, ignore writes
// [RL10] usb clock must be 48 mhz
// [RL11] summary is or of enabled flags
// [RL12] flags set at once, cleared writing zero
// [RL13] summary flag is read only status
// [RL14] time-out after over 16 idle bit times
// [RL15] all enable bits reset to zero
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ueim_defs.vh"

module ueim_top (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // error detections from the serial interface engine
    input  wire        bitstuff_err_det,
    input  wire        field_size_err_det,
    input  wire        data_crc_fail_det,
    input  wire        token_crc_err_det,
    input  wire        pid_check_err_det,
    // line timing for the turnaround watch
    input  wire        bit_tick,
    input  wire        eop_seen,
    input  wire        bus_idle,
    input  wire        reply_expected,
    // to the interrupt logic
    output reg         usb_error_summary_flag,
    output reg         usb_irq
);

    // registers
    reg  [7:0]  usb_error_irq_enable;
    reg  [7:0]  usb_error_irq_status;
    reg  [7:0]  usb_irq_enable;

    // write channel holding
    reg         aw_held;
    reg         w_held;
    reg  [3:0]  wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;

    // turnaround watch
    reg  [4:0]  idle_bits;
    reg         turn_armed;
    wire        turn_timeout;

    // write decode
    wire        wr_fire;
    wire        wr_lane0;
    wire        wr_err_status;
    wire        wr_err_enable;
    wire        wr_irq_enable;
    wire        wr_mapped;

    // status update
    reg  [7:0]  err_events;
    reg  [7:0]  next_err_status;
    wire [7:0]  enabled_errors;
    wire        next_summary;
    wire [7:0]  irq_status_view;

    // read decode
    reg  [7:0]  rd_byte;
    reg         rd_mapped;

    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0      = wr_strb[0];
    assign wr_err_status = wr_fire && wr_lane0
                           && (wr_addr == `UEIM_OFF_ERR_STATUS);
    assign wr_err_enable = wr_fire && wr_lane0
                           && (wr_addr == `UEIM_OFF_ERR_ENABLE);
    assign wr_irq_enable = wr_fire && wr_lane0
                           && (wr_addr == `UEIM_OFF_IRQ_ENABLE);
    assign wr_mapped     = (wr_addr == `UEIM_OFF_IRQ_STATUS)
                           || (wr_addr == `UEIM_OFF_IRQ_ENABLE)
                           || (wr_addr == `UEIM_OFF_ERR_STATUS)
                           || (wr_addr == `UEIM_OFF_ERR_ENABLE);

    // write address channel, held until the data also arrives
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            wr_addr       <= 4'h0;
            s_axi_awready <= 1'b0;
        end else begin
            // ready must not wait for valid to drop, or a master
            // holding valid high would stall the channel forever
            s_axi_awready <= !aw_held && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                wr_addr       <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
        end
    end

    // write data channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            wr_data      <= 32'h0000_0000;
            wr_strb      <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            // same reasoning as the address channel
            s_axi_wready <= !w_held && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                wr_data      <= s_axi_wdata;
                wr_strb      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response follows both halves
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `UEIM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `UEIM_RESP_OKAY
                                      : `UEIM_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // enable registers; absent bits never store
    always @(posedge aclk) begin
        if (!aresetn) begin
            // [RL15] enables start cleared
            usb_error_irq_enable <= `UEIM_RST_ERR_ENABLE;
            usb_irq_enable       <= `UEIM_RST_IRQ_ENABLE;
        end else begin
            // [RL9] bits 6:5 masked
            if (wr_err_enable)
                usb_error_irq_enable <= wr_data[7:0]
                                        & `UEIM_ERR_IMPL_MASK;
            if (wr_irq_enable)
                usb_irq_enable <= wr_data[7:0]
                                  & `UEIM_IRQ_EN_IMPL_MASK;
        end
    end

    // [RL14] idle bit counter after eop
    always @(posedge aclk) begin
        if (!aresetn) begin
            idle_bits  <= 5'd0;
            turn_armed <= 1'b0;
        end else if (eop_seen) begin
            idle_bits  <= 5'd0;
            turn_armed <= 1'b1;
        end else if (!bus_idle || !reply_expected || turn_timeout) begin
            idle_bits  <= 5'd0;
            turn_armed <= 1'b0;
        end else if (bit_tick) begin
            idle_bits <= idle_bits + 5'd1;
        end
    end

    // [RL14] fires on the seventeenth idle bit
    assign turn_timeout = turn_armed && bus_idle && reply_expected
                          && bit_tick && (idle_bits == `UEIM_TURN_LIMIT);

    always @* begin
        err_events = 8'h00;
        err_events[`UEIM_BIT_BITSTUFF]   = bitstuff_err_det;
        err_events[`UEIM_BIT_TURNAROUND] = turn_timeout;
        err_events[`UEIM_BIT_FIELD_SIZE] = field_size_err_det;
        err_events[`UEIM_BIT_DATA_CRC]   = data_crc_fail_det;
        err_events[`UEIM_BIT_TOKEN_CRC]  = token_crc_err_det;
        err_events[`UEIM_BIT_PID]        = pid_check_err_det;
    end

    // writing zero clears; a fresh event in the same cycle wins
    always @* begin
        next_err_status = usb_error_irq_status;
        // [RL12] clear by writing zero
        if (wr_err_status)
            next_err_status = usb_error_irq_status & wr_data[7:0];
        // [RL2] set regardless of enables
        next_err_status = (next_err_status | err_events)
                          & `UEIM_ERR_IMPL_MASK;
    end

    always @(posedge aclk) begin
        if (!aresetn)
            usb_error_irq_status <= `UEIM_RST_ERR_STATUS;
        else
            usb_error_irq_status <= next_err_status;
    end

    // [RL1] per-bit gating of flags
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gate
            // [RL3] [RL4] [RL5] [RL6] [RL7] [RL8] enable per bit
            assign enabled_errors[g] = usb_error_irq_status[g]
                                       & usb_error_irq_enable[g];
        end
    endgenerate

    // [RL11] or of enabled flags
    assign next_summary = |enabled_errors;

    // [RL13] summary only follows the flags, no write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            usb_error_summary_flag <= 1'b0;
            usb_irq                <= 1'b0;
        end else begin
            usb_error_summary_flag <= next_summary;
            usb_irq <= next_summary
                       & usb_irq_enable[`UEIM_BIT_SUMMARY];
        end
    end

    // only the summary bit is modelled here; others read zero
    assign irq_status_view = {6'b000000, usb_error_summary_flag, 1'b0};

    always @* begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b1;
        case ({s_axi_araddr[3:2], 2'b00})
            `UEIM_OFF_IRQ_STATUS: rd_byte = irq_status_view;
            `UEIM_OFF_IRQ_ENABLE: rd_byte = usb_irq_enable;
            `UEIM_OFF_ERR_STATUS: rd_byte = usb_error_irq_status;
            `UEIM_OFF_ERR_ENABLE: rd_byte = usb_error_irq_enable;
            default:              rd_mapped = 1'b0;
        endcase
    end

    // read channel: one read at a time, data held until taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `UEIM_RESP_OKAY;
        end else begin
            // free slot only; a waiting arvalid is taken next edge
            s_axi_arready <= !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, rd_byte};
                s_axi_rresp   <= rd_mapped ? `UEIM_RESP_OKAY
                                           : `UEIM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: tb/tb_usb_error_irq_masking.sv */
`timescale 1ns/1ns
`include "ueim_defs.vh"
module tb_usb_error_irq_masking;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [3:0]  s_axi_awaddr = 4'h0;
    reg  [3:0]  s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'h1;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    reg  [7:0]  ev = 8'h00;
    reg  [7:0]  b;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, usb_error_summary_flag, usb_irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        bitstuff_err_det, field_size_err_det, data_crc_fail_det;
    wire        token_crc_err_det, pid_check_err_det, bit_tick, eop_seen;
    wire        bus_idle, reply_expected;
    integer     num_errors = 0;
    integer     samples_checked = 0;
    integer     i;
    integer     t;

    ueim_top dut (.*);
    ueim_sie_model sie (.*);

    initial begin
        forever #5 aclk = ~aclk;
    end

    task chk(input [63:0] n, input [31:0] e, input [31:0] s);
        begin
            samples_checked = samples_checked + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %0s exp %h got %h", n, e, s);
            end
        end
    endtask

    task wr(input [3:0] a, input [7:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            t = 0;
            do begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                t = t + 1;
            end while (!s_axi_bvalid && t < 50);
            s_axi_bready <= 1'b0;
            chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
            chk("bresp", {30'h0, `UEIM_RESP_OKAY}, {30'h0, s_axi_bresp});
        end
    endtask

    task rd(input [3:0] a, input [7:0] e);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            t = 0;
            do begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                t = t + 1;
            end while (!s_axi_rvalid && t < 50);
            s_axi_rready <= 1'b0;
            chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
            chk("rresp", {30'h0, `UEIM_RESP_OKAY}, {30'h0, s_axi_rresp});
            chk("rdata", {24'h0, e}, s_axi_rdata);
        end
    endtask

    // flag path is registered twice, so let it settle
    task sig(input s, input q);
        begin
            repeat (4) @(posedge aclk);
            chk("summary", {31'h0, s}, {31'h0, usb_error_summary_flag});
            chk("irq", {31'h0, q}, {31'h0, usb_irq});
        end
    endtask

    task fire(input [7:0] e);
        begin
            ev <= e;
            @(posedge aclk);
            ev <= 8'h00;
            repeat (150) @(posedge aclk);
        end
    endtask

    task summarize;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors = num_errors + 1;
        summarize;
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`UEIM_OFF_ERR_ENABLE, 8'h00);
        rd(`UEIM_OFF_ERR_STATUS, 8'h00);
        wr(`UEIM_OFF_ERR_ENABLE, 8'hff);
        rd(`UEIM_OFF_ERR_ENABLE, 8'h9f);
        // a write with the low lane off leaves the register alone
        s_axi_wstrb <= 4'h0;
        wr(`UEIM_OFF_ERR_ENABLE, 8'h00);
        s_axi_wstrb <= 4'h1;
        rd(`UEIM_OFF_ERR_ENABLE, 8'h9f);
        wr(`UEIM_OFF_IRQ_ENABLE, 8'h02);
        $display("reset and access done");
        for (i = 0; i < 8; i = i + 1) if (i < 5 || i == 7) begin
            b = 8'h01 << i;
            wr(`UEIM_OFF_ERR_ENABLE, 8'h9f & ~b);
            fire(b);
            rd(`UEIM_OFF_ERR_STATUS, b);
            sig(1'b0, 1'b0);
            wr(`UEIM_OFF_ERR_ENABLE, b);
            sig(1'b1, 1'b1);
            wr(`UEIM_OFF_IRQ_STATUS, 8'h00);
            rd(`UEIM_OFF_IRQ_STATUS, 8'h02);
            wr(`UEIM_OFF_ERR_STATUS, 8'hff);
            sig(1'b1, 1'b1);
            wr(`UEIM_OFF_ERR_STATUS, 8'h00);
            sig(1'b0, 1'b0);
            $display("error bit %0d done", i);
        end
        fire(8'h20);
        rd(`UEIM_OFF_ERR_STATUS, 8'h00);
        $display("turnaround disarm done");
        wr(`UEIM_OFF_IRQ_ENABLE, 8'h00);
        fire(8'h80);
        sig(1'b1, 1'b0);
        $display("irq mask done");
        summarize;
    end
endmodule

/* File: tb/ueim_sie_model.sv */
`timescale 1ns/1ns
module ueim_sie_model (
    // one-hot error request from the bench
    input  wire       aclk,
    input  wire [7:0] ev,
    // detections and line timing
    output reg        bitstuff_err_det = 1'b0,
    output reg        field_size_err_det = 1'b0,
    output reg        data_crc_fail_det = 1'b0,
    output reg        token_crc_err_det = 1'b0,
    output reg        pid_check_err_det = 1'b0,
    output reg        bit_tick = 1'b0,
    output reg        eop_seen = 1'b0,
    output reg        bus_idle = 1'b1,
    output reg        reply_expected = 1'b0
);
    // line activity in mid-wait, to see the watch disarm
    reg               cut;
    integer           k;
    always @(posedge aclk) begin
        {bitstuff_err_det, field_size_err_det, data_crc_fail_det,
         token_crc_err_det, pid_check_err_det} <= {ev[7], ev[3:0]};
        // idle past 16 bit times, or cut by activity
        if (ev[4] || ev[5]) begin
            cut = ev[5];
            eop_seen <= 1'b1;
            reply_expected <= 1'b1;
            @(posedge aclk);
            eop_seen <= 1'b0;
            // full speed bit time, about 8 clocks
            for (k = 0; k < 17; k = k + 1) begin
                repeat (7) @(posedge aclk);
                bit_tick <= 1'b1;
                bus_idle <= !(cut && k == 8);
                @(posedge aclk);
                bit_tick <= 1'b0;
                bus_idle <= 1'b1;
            end
            reply_expected <= 1'b0;
        end
    end
endmodule

/* File: tb/ueim_top_chk.sv */
`timescale 1ns/1ns
module ueim_top_chk (
    // clock, reset and bus handshakes
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // interrupt side
    input wire        usb_error_summary_flag,
    input wire        usb_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_resp;
        s_wr_take |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    property p_rd_resp;
        s_rd_take |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no read response");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data unstable");
    property p_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_rst_idle;
        $rose(aresetn) |-> !usb_error_summary_flag && !usb_irq;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("summary set after reset");
    property p_irq_src;
        usb_irq |-> usb_error_summary_flag;
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("irq without summary");
    // a flag only clears by a write, so a fall follows a write response
    property p_sum_fall;
        $fell(usb_error_summary_flag) |-> $past(s_axi_bvalid)
            || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endproperty
    a_sum_fall: assert property (p_sum_fall)
        else $error("summary fell without write");
endmodule
bind ueim_top ueim_top_chk chk (.*);
